//--- design/mode_sel_pkg.sv
package mode_sel_pkg;
    // clock and debounce timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int DEBOUNCE_NS = 50000;
    // least time, so round up to whole cycles
    localparam int DEBOUNCE_CYCLES =
        (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEB_CNT_W = $clog2(DEBOUNCE_CYCLES + 1);

    // terminal bundle layout
    localparam int TERM_W = 4;
    localparam int TERM_EDIT = 0;
    localparam int TERM_LOCAL = 1;
    localparam int TERM_FWD = 2;
    localparam int TERM_REV = 3;

    // mode select setting
    localparam int MODE_SET_W = 4;
    localparam logic [MODE_SET_W-1:0] MODE_SET_RESET = 4'h0;
    localparam logic [MODE_SET_W-1:0] MODE_SET_EDIT = 4'h7;
    localparam logic [MODE_SET_W-1:0] MODE_SET_LOCAL = 4'h8;
    localparam logic [MODE_SET_W-1:0] MODE_SET_MAX = 4'h8;

    // second ramp time value that unlocks the edit scheme
    localparam int RAMP_W = 14;
    localparam logic [RAMP_W-1:0] RAMP_UNSET = 14'h270f;

    typedef enum logic [0:0] {
        OP_EXTERNAL = 1'b0,
        OP_KEYPAD = 1'b1
    } op_mode_t;
endpackage

//--- design/mode_sel_if.sv
`timescale 1ns/1ns
// debounced terminal levels
interface term_if;
    import mode_sel_pkg::*;
    logic [TERM_W-1:0] level;
    modport source (output level);
    modport sink (input level);
endinterface

// parameter write qualification
interface wrgate_if;
    logic keypadMode;
    logic editScheme;
    logic editClosed;
    logic running;
    logic wrReq;
    logic runChangeable;
    logic wrAccept;
    logic wrReject;
    modport gate (input keypadMode, editScheme, editClosed, running,
        wrReq, runChangeable, output wrAccept, wrReject);
    modport ctrl (output keypadMode, editScheme, editClosed, running,
        wrReq, runChangeable, input wrAccept, wrReject);
endinterface

//--- design/input_conditioner.sv
`timescale 1ns/1ns
module input_conditioner
    import mode_sel_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // raw contact levels
    input wire logic [TERM_W-1:0] rawIn,
    // debounced levels
    term_if.source terms
);
    logic [TERM_W-1:0] meta_q;
    logic [TERM_W-1:0] sync_q;
    logic [DEB_CNT_W-1:0] cnt_q [TERM_W];

    // two-flop synchroniser, first stage read only by the second
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= rawIn;
            sync_q <= meta_q;
        end
    end

    // a level must hold the full window before it is taken [R18]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            terms.level <= '0;
            for (int i = 0; i < TERM_W; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < TERM_W; i++) begin
                if (sync_q[i] == terms.level[i]) begin
                    cnt_q[i] <= '0;
                end else if (cnt_q[i] == DEB_CNT_W'(DEBOUNCE_CYCLES - 1)) begin
                    terms.level[i] <= sync_q[i]; // [R18]
                    cnt_q[i] <= '0;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 1'b1;
                end
            end
        end
    end
endmodule

//--- design/param_write_gate.sv
`timescale 1ns/1ns
module param_write_gate
    import mode_sel_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // qualification and answer
    wrgate_if.gate wr
);
    logic allowed;

    // writes only from the keypad; edit scheme also needs the terminal
    always_comb begin
        allowed = wr.keypadMode && (!wr.editScheme || wr.editClosed); // [R1]
        if (wr.running && !wr.runChangeable) begin
            allowed = 1'b0; // [R17]
        end
    end

    // one-cycle answer to each request
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr.wrAccept <= 1'b0;
            wr.wrReject <= 1'b0;
        end else begin
            wr.wrAccept <= wr.wrReq && allowed;
            wr.wrReject <= wr.wrReq && !allowed; // [R1] [R17]
        end
    end
endmodule

//--- design/drive_operation_mode_selector.sv
`timescale 1ns/1ns
// Functional notes
// R1: setting 7: parameter writes only while edit terminal closed.
// R2: setting 7, terminal closed: output shut off in external mode.
// R3: setting 7, terminal closed: keypad mode allowed and runs the drive.
// R4: setting 7, terminal open: forced into external mode.
// R5: setting 7, terminal open: keypad mode requests refused.
// R6: value 7 accepted only when second ramp time holds 9999.
// R7: terminal opening in keypad forces external, starts then drive motor.
// R8: leaving setting 7 restores ordinary shutoff, new setting applies.
// R9: terminal on: no external/keypad change while a start input is on.
// R10: ordinary shutoff ignored while in keypad mode.
// R11: every forced keypad-to-external change resets keypad unit once.
// R12: alarm reset by keypad stop key in keypad mode only.
// R13: drive reset always lands in keypad mode.
// R14: setting 8: local/auto closed fixes external, open fixes keypad.
// R15: setting 8: terminal change only while stopped, deferred while running.
// R16: setting 8: high-speed input becomes local/auto, speed select disabled.
// R17: while running, writes limited to run-changeable parameters.
// R18: contacts synchronised and debounced, one change one transition.
module drive_operation_mode_selector
    import mode_sel_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // contact terminals, high while closed to input_common
    input wire logic editEnableShutoffInput,
    input wire logic localAutoSelectInput,
    input wire logic forwardStartInput,
    input wire logic reverseStartInput,
    // keypad unit requests, one-cycle pulses
    input wire logic keypadModeReq,
    input wire logic externalModeReq,
    input wire logic keypadStopKey,
    // keypad run keys, levels
    input wire logic keypadForward,
    input wire logic keypadReverse,
    // mode select setting write
    input wire logic modeSetWr,
    input wire logic [MODE_SET_W-1:0] modeSetData,
    input wire logic [RAMP_W-1:0] secondRampTimeSetting,
    // parameter write request
    input wire logic paramWrReq,
    input wire logic paramRunChangeable,
    // drive status
    input wire logic driveRunning,
    input wire logic alarmActive,
    // mode and setting state
    output logic keypadMode,
    output logic [MODE_SET_W-1:0] modeSelectSetting,
    output logic modeSetAccept,
    output logic modeSetReject,
    output logic modeReqRefused,
    // drive commands
    output logic outputShutoff,
    output logic runForward,
    output logic runReverse,
    output logic highSpeedSelect,
    // pulses toward keypad unit and drive
    output logic keypadUnitReset,
    output logic alarmReset,
    // parameter write answer
    output logic paramWrAccept,
    output logic paramWrReject
);
    term_if terms ();
    wrgate_if wr ();

    op_mode_t mode_q;
    op_mode_t mode_d;
    logic [MODE_SET_W-1:0] modeSet_q;
    logic setAccept_q;
    logic setReject_q;
    logic refused_q;
    logic refused_d;
    logic forced_d;
    logic unitReset_q;
    logic alarmReset_q;
    logic shutoff_q;
    logic runFwd_q;
    logic runRev_q;
    logic hiSpeed_q;

    logic editClosed;
    logic localClosed;
    logic fwdOn;
    logic revOn;
    logic startOn;
    logic editScheme;
    logic localScheme;

    // contact inputs cross into the clock domain here
    input_conditioner u_cond (
        .clk(clk),
        .reset_n(reset_n),
        .rawIn({reverseStartInput, forwardStartInput,
            localAutoSelectInput, editEnableShutoffInput}),
        .terms(terms.source)
    );

    // only debounced levels feed mode decisions
    assign editClosed = terms.level[TERM_EDIT]; // [R18]
    assign localClosed = terms.level[TERM_LOCAL];
    assign fwdOn = terms.level[TERM_FWD];
    assign revOn = terms.level[TERM_REV];
    assign startOn = fwdOn || revOn;
    assign editScheme = (modeSet_q == MODE_SET_EDIT);
    assign localScheme = (modeSet_q == MODE_SET_LOCAL);

    // checks a requested setting; 7 needs the unset ramp time
    function automatic logic setting_ok(
        input logic [MODE_SET_W-1:0] val,
        input logic [RAMP_W-1:0] ramp
    );
        logic ok;
        ok = (val <= MODE_SET_MAX);
        if (val == MODE_SET_EDIT && ramp != RAMP_UNSET) begin
            ok = 1'b0; // [R6]
        end
        return ok;
    endfunction

    // mode select setting register
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modeSet_q <= MODE_SET_RESET;
            setAccept_q <= 1'b0;
            setReject_q <= 1'b0;
        end else begin
            setAccept_q <= 1'b0;
            setReject_q <= 1'b0;
            if (modeSetWr) begin
                if (setting_ok(modeSetData, secondRampTimeSetting)) begin
                    // leaving 7 hands the terminal back to shutoff [R8]
                    modeSet_q <= modeSetData;
                    setAccept_q <= 1'b1;
                end else begin
                    setReject_q <= 1'b1; // [R6]
                end
            end
        end
    end

    // next operation mode, per active scheme
    always_comb begin
        mode_d = mode_q;
        refused_d = 1'b0;
        forced_d = 1'b0;
        if (editScheme) begin
            if (!editClosed) begin
                // open terminal overrides the start inputs [R4] [R7]
                if (mode_q == OP_KEYPAD) begin
                    mode_d = OP_EXTERNAL;
                    forced_d = 1'b1; // [R11]
                end
                refused_d = keypadModeReq; // [R5]
            end else if (keypadModeReq && mode_q == OP_EXTERNAL) begin
                if (startOn) begin
                    refused_d = 1'b1; // [R9]
                end else begin
                    mode_d = OP_KEYPAD; // [R3]
                end
            end else if (externalModeReq && mode_q == OP_KEYPAD) begin
                if (startOn) begin
                    refused_d = 1'b1; // [R9]
                end else begin
                    mode_d = OP_EXTERNAL;
                end
            end
        end else if (localScheme) begin
            // requests from the keypad never move the mode here [R14]
            refused_d = keypadModeReq || externalModeReq;
            if (!driveRunning) begin
                // held off until the drive stops [R15]
                if (localClosed && mode_q == OP_KEYPAD) begin
                    mode_d = OP_EXTERNAL; // [R14]
                    forced_d = 1'b1; // [R11]
                end else if (!localClosed && mode_q == OP_EXTERNAL) begin
                    mode_d = OP_KEYPAD; // [R14]
                end
            end
        end else begin
            // other settings: plain requests, not while a start is on with the edit terminal closed
            if (keypadModeReq && mode_q == OP_EXTERNAL) begin
                if (startOn && editClosed) begin
                    refused_d = 1'b1; // [R9]
                end else begin
                    mode_d = OP_KEYPAD;
                end
            end else if (externalModeReq && mode_q == OP_KEYPAD) begin
                if (startOn && editClosed) begin
                    refused_d = 1'b1; // [R9]
                end else begin
                    mode_d = OP_EXTERNAL;
                end
            end
        end
        // a keypad alarm reset resets the drive, back to keypad mode
        if (alarmReset_q) begin
            mode_d = OP_KEYPAD; // [R13]
            forced_d = 1'b0;
        end
    end

    // operation mode register; reset lands in keypad mode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_q <= OP_KEYPAD; // [R13]
            refused_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            refused_q <= refused_d;
        end
    end

    // one-shot keypad unit reset on each forced exit
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            unitReset_q <= 1'b0;
        end else begin
            unitReset_q <= forced_d; // [R11]
        end
    end

    // alarm reset only from the stop key in keypad mode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alarmReset_q <= 1'b0;
        end else begin
            alarmReset_q <= keypadStopKey && alarmActive
                && mode_q == OP_KEYPAD && !alarmReset_q; // [R12]
        end
    end

    // shutoff: terminal closed while external; keypad mode ignores it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shutoff_q <= 1'b0;
        end else begin
            // same form under 7 and as ordinary shutoff otherwise [R2] [R8]
            shutoff_q <= editClosed && mode_d == OP_EXTERNAL; // [R10]
        end
    end

    // run commands come from terminals or keypad keys by mode
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            runFwd_q <= 1'b0;
            runRev_q <= 1'b0;
        end else if (mode_d == OP_KEYPAD) begin
            // under 7 the keypad runs only with the terminal closed [R3]
            runFwd_q <= keypadForward && !keypadReverse
                && (!editScheme || editClosed);
            runRev_q <= keypadReverse && !keypadForward
                && (!editScheme || editClosed);
        end else begin
            // conflicting starts cancel rather than pick a direction
            runFwd_q <= fwdOn && !revOn && !(editClosed); // [R7]
            runRev_q <= revOn && !fwdOn && !(editClosed); // [R7]
        end
    end

    // high-speed select is lost to local/auto under setting 8
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hiSpeed_q <= 1'b0;
        end else begin
            hiSpeed_q <= localClosed && !localScheme; // [R16]
        end
    end

    // parameter write qualification
    assign wr.keypadMode = (mode_q == OP_KEYPAD);
    assign wr.editScheme = editScheme;
    assign wr.editClosed = editClosed;
    assign wr.running = driveRunning;
    assign wr.wrReq = paramWrReq;
    assign wr.runChangeable = paramRunChangeable;

    param_write_gate u_gate (
        .clk(clk),
        .reset_n(reset_n),
        .wr(wr.gate)
    );

    // outputs, each straight from a flip-flop
    assign keypadMode = mode_q;
    assign modeSelectSetting = modeSet_q;
    assign modeSetAccept = setAccept_q;
    assign modeSetReject = setReject_q;
    assign modeReqRefused = refused_q;
    assign outputShutoff = shutoff_q;
    assign runForward = runFwd_q;
    assign runReverse = runRev_q;
    assign highSpeedSelect = hiSpeed_q;
    assign keypadUnitReset = unitReset_q;
    assign alarmReset = alarmReset_q;
    assign paramWrAccept = wr.wrAccept;
    assign paramWrReject = wr.wrReject;
endmodule

//--- testbench/drive_mode_chk.sv
`timescale 1ns/1ns
module drive_mode_chk
    import mode_sel_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // requests
    input wire logic keypadModeReq,
    input wire logic externalModeReq,
    input wire logic keypadStopKey,
    input wire logic modeSetWr,
    input wire logic [MODE_SET_W-1:0] modeSetData,
    input wire logic [RAMP_W-1:0] secondRampTimeSetting,
    input wire logic paramWrReq,
    input wire logic paramRunChangeable,
    input wire logic driveRunning,
    input wire logic alarmActive,
    // answers
    input wire logic keypadMode,
    input wire logic [MODE_SET_W-1:0] modeSelectSetting,
    input wire logic modeSetAccept,
    input wire logic modeSetReject,
    input wire logic modeReqRefused,
    input wire logic outputShutoff,
    input wire logic highSpeedSelect,
    input wire logic keypadUnitReset,
    input wire logic alarmReset,
    input wire logic paramWrReject
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // setting writes, both answers
    AST_SET_REJ: assert property (
        modeSetWr && modeSetData == MODE_SET_EDIT &&
        secondRampTimeSetting != RAMP_UNSET |=> modeSetReject)
        else $error("setting 7 taken without unset ramp");
    AST_SET_ACC: assert property (
        modeSetWr && modeSetData == MODE_SET_EDIT &&
        secondRampTimeSetting == RAMP_UNSET |=>
        modeSetAccept && modeSelectSetting == MODE_SET_EDIT)
        else $error("setting 7 refused with unset ramp");
    // reset must land in keypad mode, so no disable here
    AST_RESET: assert property (
        @(posedge clk) disable iff (1'b0) !reset_n |=> keypadMode)
        else $error("reset left external mode");
    AST_SHUTOFF: assert property (
        keypadMode |-> !outputShutoff)
        else $error("shutoff active in keypad mode");
    // parameter write gating
    AST_PWR_EXT: assert property (
        paramWrReq && !keypadMode |=> paramWrReject)
        else $error("write taken in external mode");
    AST_PWR_RUN: assert property (
        paramWrReq && driveRunning && !paramRunChangeable
        |=> paramWrReject)
        else $error("fixed parameter written while running");
    // a fall not asked for by the keypad is forced
    AST_FORCE: assert property (
        $fell(keypadMode) && !$past(externalModeReq)
        |-> keypadUnitReset)
        else $error("forced change without keypad unit reset");
    AST_ONCE: assert property (
        keypadUnitReset |=> !keypadUnitReset)
        else $error("keypad unit reset longer than one cycle");
    // alarm reset only from keypad mode
    AST_ALARM: assert property (
        keypadStopKey && alarmActive && keypadMode |=> alarmReset)
        else $error("stop key did not reset alarm");
    AST_NO_ALARM: assert property (
        keypadStopKey && !keypadMode |=> !alarmReset)
        else $error("alarm reset from external mode");
    AST_REQ8: assert property (
        (keypadModeReq || externalModeReq) &&
        modeSelectSetting == MODE_SET_LOCAL |=> modeReqRefused)
        else $error("mode request not refused at setting 8");
    AST_HS8: assert property (
        modeSelectSetting == MODE_SET_LOCAL &&
        $past(modeSelectSetting) == MODE_SET_LOCAL |-> !highSpeedSelect)
        else $error("high speed select active at setting 8");
endmodule

bind drive_operation_mode_selector drive_mode_chk u_chk (.*);

//--- testbench/contact_model.sv
`timescale 1ns/1ns
module contact_model (
    // clock
    input wire logic clk,
    // wanted positions, high while closed
    input wire logic [3:0] want,
    // levels at the terminals
    output logic [3:0] pins
);
    logic [3:0] prev_q = 4'h0;
    logic [3:0] chg_q = 4'h0;
    logic [3:0] cnt_q = 4'h0;
    // real contacts chatter after each throw, well inside debounce
    always @(posedge clk) begin
        if (want !== prev_q) begin
            prev_q <= want;
            chg_q <= want ^ prev_q;
            cnt_q <= 4'hf;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    // odd counts show the old position of moving contacts
    assign pins = cnt_q[0] ? prev_q ^ chg_q : prev_q;
endmodule

//--- testbench/test_drive_operation_mode_selector.sv
`timescale 1ns/1ns
module test_drive_operation_mode_selector;
    import mode_sel_pkg::*;
    localparam int SETTLE = DEBOUNCE_CYCLES + 60;
    localparam logic [4:0] KREQ = 5'h01;
    localparam logic [4:0] XREQ = 5'h02;
    localparam logic [4:0] STOP = 5'h04;
    localparam logic [4:0] SETW = 5'h08;
    localparam logic [4:0] PWR = 5'h10;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] want = 4'h0;
    logic [3:0] pins;
    logic [4:0] pls = 5'h00;
    logic keypadForward = 1'b0;
    logic keypadReverse = 1'b0;
    logic driveRunning = 1'b0;
    logic alarmActive = 1'b0;
    logic paramRunChangeable = 1'b0;
    logic [MODE_SET_W-1:0] modeSetData = 4'h0;
    logic [RAMP_W-1:0] secondRampTimeSetting = 14'h0000;
    logic keypadMode, modeSetAccept, modeSetReject, modeReqRefused;
    logic outputShutoff, runForward, runReverse, highSpeedSelect;
    logic keypadUnitReset, alarmReset, paramWrAccept, paramWrReject;
    logic [MODE_SET_W-1:0] modeSelectSetting;
    int errCount = 0;
    int cmpCount = 0;
    int unitRst = 0;
    integer seed = 83945;
    logic r, c;

    // 50 MHz bench clock
    initial begin
        forever #10 clk = ~clk;
    end

    contact_model u_contacts (.clk(clk), .want(want), .pins(pins));

    drive_operation_mode_selector u_dut (
        .*,
        .editEnableShutoffInput(pins[0]),
        .localAutoSelectInput(pins[1]),
        .forwardStartInput(pins[2]),
        .reverseStartInput(pins[3]),
        .keypadModeReq(pls[0]),
        .externalModeReq(pls[1]),
        .keypadStopKey(pls[2]),
        .modeSetWr(pls[3]),
        .paramWrReq(pls[4])
    );

    // count keypad unit resets so stray pulses show up
    always @(posedge clk) begin
        if (keypadUnitReset === 1'b1) unitRst++;
    end

    task automatic check(input logic got, input logic exp);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %0t got %b exp %b", $time, got, exp);
        end
    endtask

    // one-cycle request, answer looked at just after the next edge
    task automatic pulse(input logic [4:0] p, input logic [3:0] d);
        @(posedge clk);
        pls <= p;
        modeSetData <= d;
        @(posedge clk);
        pls <= 5'h00;
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // sync plus debounce plus chatter must pass before a level counts
    task automatic term(input logic [3:0] w);
        @(posedge clk);
        want <= w;
        idle(SETTLE);
    endtask

    function automatic logic expWr(input logic run, input logic chg);
        return !(run && !chg);
    endfunction

    task automatic printVerdict;
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, well beyond the eight terminal settles
    initial begin
        repeat (40000) @(posedge clk);
        errCount++;
        $display("MISMATCH %0t watchdog expired", $time);
        printVerdict;
    end

    initial begin
        // reset seen low at exactly six edges
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        check(keypadMode, 1'b1);
        @(posedge clk) secondRampTimeSetting <= 14'({$random(seed)} % 9999);
        pulse(SETW, 4'h7);
        check(modeSetReject, 1'b1);
        check(modeSelectSetting === 4'h0, 1'b1);
        @(posedge clk) secondRampTimeSetting <= RAMP_UNSET;
        pulse(SETW, 4'h7);
        check(modeSetAccept, 1'b1);
        idle(3);
        check(keypadMode, 1'b0);
        check(unitRst == 1, 1'b1);
        pulse(KREQ, 4'h7);
        check(modeReqRefused, 1'b1);
        pulse(PWR, 4'h7);
        check(paramWrReject, 1'b1);
        term(4'h1);
        check(outputShutoff, 1'b1);
        term(4'h5);
        pulse(KREQ, 4'h7);
        check(keypadMode, 1'b0);
        term(4'h1);
        check(unitRst == 1, 1'b1);
        pulse(KREQ, 4'h7);
        check(keypadMode, 1'b1);
        check(outputShutoff, 1'b0);
        for (int i = 0; i < 12; i++) begin
            r = 1'($random(seed));
            c = 1'($random(seed));
            @(posedge clk) driveRunning <= r;
            paramRunChangeable <= c;
            pulse(PWR, 4'h7);
            check(paramWrAccept, expWr(r, c));
            check(paramWrReject, !expWr(r, c));
        end
        @(posedge clk) driveRunning <= 1'b0;
        alarmActive <= 1'b1;
        keypadForward <= 1'b1;
        pulse(STOP, 4'h7);
        check(alarmReset, 1'b1);
        check(runForward, 1'b1);
        term(4'h8);
        check(keypadMode, 1'b0);
        check(runReverse, 1'b1);
        check(runForward, 1'b0);
        check(unitRst == 2, 1'b1);
        pulse(STOP, 4'h7);
        check(alarmReset, 1'b0);
        @(posedge clk) alarmActive <= 1'b0;
        keypadForward <= 1'b0;
        term(4'h2);
        check(highSpeedSelect, 1'b1);
        @(posedge clk) driveRunning <= 1'b1;
        pulse(SETW, 4'h8);
        check(modeSetAccept, 1'b1);
        idle(2);
        check(highSpeedSelect, 1'b0);
        pulse(KREQ, 4'h8);
        check(modeReqRefused, 1'b1);
        check(keypadMode, 1'b0);
        term(4'h0);
        check(keypadMode, 1'b0);
        @(posedge clk) driveRunning <= 1'b0;
        idle(3);
        check(keypadMode, 1'b1);
        pulse(XREQ, 4'h8);
        check(modeReqRefused, 1'b1);
        term(4'h2);
        check(keypadMode, 1'b0);
        check(unitRst == 3, 1'b1);
        pulse(SETW, 4'h9);
        check(modeSetReject, 1'b1);
        check(modeSelectSetting === MODE_SET_LOCAL, 1'b1);
        term(4'h1);
        check(keypadMode, 1'b1);
        pulse(SETW, 4'h7);
        check(modeSetAccept, 1'b1);
        // leave 7 in keypad mode with the terminal still closed
        pulse(SETW, 4'h0);
        check(keypadMode, 1'b1);
        check(outputShutoff, 1'b0);
        pulse(XREQ, 4'h0);
        check(keypadMode, 1'b0);
        check(outputShutoff, 1'b1);
        check(unitRst == 3, 1'b1);
        printVerdict;
    end
endmodule
